// [hw/instr_exec.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - nibble swap writes memory, flags kept
// - nibble swap into accumulator, memory kept
// - zero byte skips next, rewrites byte
// - copy byte to accumulator, skip if zero
// - clear selected bit skips next instruction
// - page read: both pointers, low/high split
// - last page read uses low pointer only
// - increment low pointer, then page read
// - increment low pointer, then last-page read
// - xor to accumulator or memory, zero only
// - far forms address any section directly
// - add with carry, five arithmetic flags
// - plain add, five arithmetic flags
// - and to accumulator or memory, zero
// - far clear writes zero, flags kept
// - far bit clear touches one bit only
// - far complement into memory, zero flag
// - far complement into accumulator, zero flag
// - decimal adjust into memory, carry only
// - far decrement, zero flag
// - far increment, zero flag
module instr_exec
  import instr_exec_pkg::*;
#(
  parameter int DM_AW = 8,
  parameter int PM_AW = 9,
  parameter int PM_W  = 16
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);
  localparam int BANK_W = DM_AW - SECT_W;

  logic [7:0]       dmem [2**DM_AW];
  logic [PM_W-1:0]  pmem [2**PM_AW];
  logic [OP_W-1:0]  op_reg;
  logic [2:0]       bit_reg;
  logic [7:0]       imm_reg;
  logic [DM_AW-1:0] daddr_reg;
  logic [BANK_W-1:0] bank_reg;
  logic [7:0]       acc_reg;
  logic [7:0]       table_pointer_low_reg;
  logic [7:0]       table_pointer_high_reg;
  logic [7:0]       table_read_high_latch_reg;
  logic [FLG_N-1:0] flags_reg;
  logic             skip_reg;
  logic             bad_reg;
  logic [PM_AW-1:0] paddr_reg;
  exec_state_e      state_reg;
  exec_state_e      state_next;
  logic             dp_valid_reg;
  logic             dp_write_reg;
  logic [7:0]       dp_addr_reg;
  logic             hreadyout_reg;
  logic             hresp_reg;
  logic [31:0]      hrdata_reg;
  logic [31:0]      rd_word;

  function automatic logic far_op(input logic [OP_W-1:0] op);
    return op >= OP_FADC;
  endfunction

  function automatic logic inc_op(input logic [OP_W-1:0] op);
    return (op == OP_ITRD) || (op == OP_ITRDL);
  endfunction

  // bus phase tracking; every data phase takes at least one wait state
  // so that reads always see the state left by a finished instruction
  logic ap_take;
  logic bus_serve;
  logic bus_wr;
  assign ap_take   = hsel && hready && htrans[1] && !dp_valid_reg;
  assign bus_serve = dp_valid_reg && (state_reg == ST_IDLE);
  assign bus_wr    = bus_serve && dp_write_reg;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dp_valid_reg  <= 1'b0;
      dp_write_reg  <= 1'b0;
      dp_addr_reg   <= BYTE_RST;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= RESP_OKAY;
    end else begin
      hresp_reg <= RESP_OKAY;
      if (ap_take) begin
        dp_valid_reg  <= 1'b1;
        dp_write_reg  <= hwrite;
        dp_addr_reg   <= (|haddr[31:8]) ? NOMAP_OFS : haddr[7:0];
        hreadyout_reg <= 1'b0;
      end else if (bus_serve) begin
        dp_valid_reg  <= 1'b0;
        hreadyout_reg <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    case (dp_addr_reg)
      INSTR_OFS: begin
        rd_word[OP_LSB +: OP_W] = op_reg;
        rd_word[BIT_LSB +: 3]   = bit_reg;
        rd_word[IMM_LSB +: 8]   = imm_reg;
      end
      DADDR_OFS: rd_word[DM_AW-1:0] = daddr_reg;
      ACC_OFS:   rd_word[7:0] = acc_reg;
      STAT_OFS: begin
        rd_word[FLG_N-1:0] = flags_reg;
        rd_word[STAT_SKIP] = skip_reg;
        rd_word[STAT_BAD]  = bad_reg;
      end
      TBL_OFS: begin
        rd_word[7:0]            = table_pointer_low_reg;
        rd_word[TABLE_POINTER_HIGH_LSB +: 8]  = table_pointer_high_reg;
        rd_word[TABLE_READ_HIGH_LATCH_LSB +: 8]  = table_read_high_latch_reg;
      end
      BANK_OFS:  rd_word[BANK_W-1:0] = bank_reg;
      DMEM_OFS:  rd_word[7:0] = dmem[daddr_reg];
      PADDR_OFS: rd_word[PM_AW-1:0] = paddr_reg;
      PDATA_OFS: rd_word[PM_W-1:0] = pmem[paddr_reg];
      default:   rd_word = '0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      hrdata_reg <= '0;
    end else if (bus_serve && !dp_write_reg) begin
      hrdata_reg <= rd_word;
    end
  end

  // operand fetch
  logic [DM_AW-1:0] ea;
  logic [7:0]       m;
  logic [7:0]       swapped;
  logic [7:0]       table_pointer_low_inc;
  logic [7:0]       tp_low;
  logic [PM_AW-1:0] pm_addr;
  logic [PM_W-1:0]  pm_word;
  logic             last_page;
  // far forms bypass the bank select
  assign ea = far_op(op_reg) ? daddr_reg :
              {bank_reg, daddr_reg[SECT_W-1:0]};
  assign m        = dmem[ea];
  assign swapped  = {m[3:0], m[7:4]};
  assign table_pointer_low_inc = table_pointer_low_reg + 8'h01;
  assign tp_low   = inc_op(op_reg) ? table_pointer_low_inc : table_pointer_low_reg;
  assign last_page = (op_reg == OP_TRDL) || (op_reg == OP_ITRDL);
  assign pm_addr  = last_page ? {{(PM_AW-8){1'b1}}, tp_low} :
                    PM_AW'({table_pointer_high_reg, tp_low});
  assign pm_word  = pmem[pm_addr];

  // arithmetic
  logic       cin;
  logic [8:0] sum;
  logic [4:0] half;
  logic [7:0] low7;
  logic       lo_adj;
  logic       hi_adj;
  logic [8:0] daa_sum;
  assign cin  = ((op_reg == OP_FADC) || (op_reg == OP_FADCM)) &&
                flags_reg[FLG_C];
  assign sum  = {1'b0, acc_reg} + {1'b0, m} + {8'h00, cin};
  assign half = {1'b0, acc_reg[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
  assign low7 = {1'b0, acc_reg[6:0]} + {1'b0, m[6:0]} + {7'h00, cin};
  assign lo_adj  = (acc_reg[3:0] > NIB_MAX) || flags_reg[FLG_AC];
  assign hi_adj  = (acc_reg[7:4] > NIB_MAX) || flags_reg[FLG_C];
  assign daa_sum = {1'b0, acc_reg} +
                   {1'b0, (hi_adj ? BCD_ADJ : 4'h0), (lo_adj ? BCD_ADJ : 4'h0)};

  logic [7:0]       res;
  logic             to_acc;
  logic             to_mem;
  logic             set_z;
  logic             set_arith;
  logic             skip_now;
  logic             tbl_rd;
  logic             bad_now;
  logic [FLG_N-1:0] flags_next;

  always_comb begin
    res       = m;
    to_acc    = 1'b0;
    to_mem    = 1'b0;
    set_z     = 1'b0;
    set_arith = 1'b0;
    skip_now  = 1'b0;
    tbl_rd    = 1'b0;
    bad_now   = 1'b0;
    flags_next = flags_reg;
    case (op_reg)
      OP_SWAP: begin
        res = swapped;
        to_mem = 1'b1;
      end
      OP_NIBBLE_EXCHANGE_TO_ACC: begin
        res = swapped;
        to_acc = 1'b1;
      end
      OP_SZ: begin
        to_mem = 1'b1;
        skip_now = (m == BYTE_RST);
      end
      OP_SZA: begin
        to_acc = 1'b1;
        skip_now = (m == BYTE_RST);
      end
      OP_SZ_BIT: skip_now = !m[bit_reg];
      OP_TRD, OP_TRDL, OP_ITRD, OP_ITRDL: begin
        res = pm_word[7:0];
        to_mem = 1'b1;
        tbl_rd = 1'b1;
      end
      OP_XOR, OP_XOR_TO_MEMORY, OP_XORI: begin
        res = acc_reg ^ ((op_reg == OP_XORI) ? imm_reg : m);
        to_acc = (op_reg != OP_XOR_TO_MEMORY);
        to_mem = (op_reg == OP_XOR_TO_MEMORY);
        set_z = 1'b1;
      end
      OP_FADC, OP_FADCM, OP_FADD, OP_FADDM: begin
        res = sum[7:0];
        to_acc = (op_reg == OP_FADC) || (op_reg == OP_FADD);
        to_mem = !to_acc;
        set_arith = 1'b1;
      end
      OP_FAND, OP_FANDM: begin
        res = acc_reg & m;
        to_acc = (op_reg == OP_FAND);
        to_mem = (op_reg == OP_FANDM);
        set_z = 1'b1;
      end
      OP_FCLR: begin
        res = BYTE_RST;
        to_mem = 1'b1;
      end
      OP_FCLR_BIT: begin
        res = m & ~(8'h01 << bit_reg);
        to_mem = 1'b1;
      end
      OP_FCPL, OP_FCPLA: begin
        res = ~m;
        to_acc = (op_reg == OP_FCPLA);
        to_mem = (op_reg == OP_FCPL);
        set_z = 1'b1;
      end
      OP_FDAA: begin
        res = daa_sum[7:0];
        to_mem = 1'b1;
        flags_next[FLG_C] = flags_reg[FLG_C] | hi_adj | daa_sum[8];
      end
      OP_FDEC, OP_FDECA: begin
        res = m - 8'h01;
        to_acc = (op_reg == OP_FDECA);
        to_mem = (op_reg == OP_FDEC);
        set_z = 1'b1;
      end
      OP_FINC, OP_FINCA: begin
        res = m + 8'h01;
        to_acc = (op_reg == OP_FINCA);
        to_mem = (op_reg == OP_FINC);
        set_z = 1'b1;
      end
      default: bad_now = 1'b1;
    endcase
    if (set_z || set_arith) begin
      flags_next[FLG_Z] = (res == BYTE_RST);
    end
    if (set_arith) begin
      flags_next[FLG_C]  = sum[8];
      flags_next[FLG_AC] = half[4];
      flags_next[FLG_OV] = low7[7] ^ sum[8];
      flags_next[FLG_SC] = low7[7] ^ sum[8] ^ sum[7];
    end
  end

  // a skip inserts one dummy cycle; everything else retires in one
  always_comb begin
    case (state_reg)
      ST_IDLE:  state_next = (bus_wr && dp_addr_reg == INSTR_OFS) ?
                             ST_EXEC : ST_IDLE;
      ST_EXEC:  state_next = skip_now ? ST_DUMMY : ST_IDLE;
      ST_DUMMY: state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  logic exec_now;
  assign exec_now = (state_reg == ST_EXEC);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      op_reg    <= OP_RST;
      bit_reg   <= '0;
      imm_reg   <= BYTE_RST;
      daddr_reg <= '0;
      bank_reg  <= '0;
      paddr_reg <= '0;
    end else if (bus_wr) begin
      case (dp_addr_reg)
        INSTR_OFS: begin
          op_reg  <= hwdata[OP_LSB +: OP_W];
          bit_reg <= hwdata[BIT_LSB +: 3];
          imm_reg <= hwdata[IMM_LSB +: 8];
        end
        DADDR_OFS: daddr_reg <= hwdata[DM_AW-1:0];
        BANK_OFS:  bank_reg  <= hwdata[BANK_W-1:0];
        PADDR_OFS: paddr_reg <= hwdata[PM_AW-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      acc_reg <= BYTE_RST;
    end else if (exec_now && to_acc) begin
      acc_reg <= res;
    end else if (bus_wr && dp_addr_reg == ACC_OFS) begin
      acc_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flags_reg <= FLAGS_RST;
      skip_reg  <= 1'b0;
      bad_reg   <= 1'b0;
    end else if (exec_now) begin
      flags_reg <= flags_next;
      skip_reg  <= skip_now;
      bad_reg   <= bad_now;
    end else if (bus_wr && dp_addr_reg == STAT_OFS) begin
      flags_reg <= hwdata[FLG_N-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      table_pointer_low_reg <= BYTE_RST;
      table_pointer_high_reg <= BYTE_RST;
      table_read_high_latch_reg <= BYTE_RST;
    end else if (exec_now && tbl_rd) begin
      table_read_high_latch_reg <= pm_word[8 +: 8];
      if (inc_op(op_reg)) begin
        table_pointer_low_reg <= table_pointer_low_inc;
      end
    end else if (bus_wr && dp_addr_reg == TBL_OFS) begin
      table_pointer_low_reg <= hwdata[7:0];
      table_pointer_high_reg <= hwdata[TABLE_POINTER_HIGH_LSB +: 8];
    end
  end

  // memories hold no reset: software loads them before use
  always_ff @(posedge ref_clk) begin
    if (exec_now && to_mem) begin
      dmem[ea] <= res;
    end else if (bus_wr && dp_addr_reg == DMEM_OFS) begin
      dmem[daddr_reg] <= hwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (bus_wr && dp_addr_reg == PDATA_OFS) begin
      pmem[paddr_reg] <= hwdata[PM_W-1:0];
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hrdata    = hrdata_reg;
  assign hresp     = hresp_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  logic [FLG_N-1:0] fl_nz;
  logic [FLG_N-1:0] fl_nc;
  logic             m_zero;
  assign fl_nz  = flags_reg & ~Z_MASK;
  assign fl_nc  = flags_reg & ~C_MASK;
  assign m_zero = (m == BYTE_RST);

  swap_mem_a: assert property (
    exec_now && op_reg == OP_SWAP |=> dmem[$past(ea)] == $past(swapped)
      && flags_reg == $past(flags_reg))
    else $error("nibble swap to memory wrong");
  swap_acc_a: assert property (
    exec_now && op_reg == OP_NIBBLE_EXCHANGE_TO_ACC |=> acc_reg == $past(swapped)
      && dmem[$past(ea)] == $past(m))
    else $error("nibble swap to accumulator wrong");
  skip_two_a: assert property (
    exec_now && skip_now |=> state_reg == ST_DUMMY ##1 state_reg == ST_IDLE)
    else $error("skip did not take one dummy cycle");
  copy_skip_a: assert property (
    exec_now && op_reg == OP_SZA |=> acc_reg == $past(m)
      && (state_reg == ST_DUMMY) == $past(m_zero))
    else $error("copy-and-skip wrong");
  one_cycle_a: assert property (
    exec_now && !skip_now |=> state_reg == ST_IDLE)
    else $error("non-skip instruction overran one cycle");
  tbl_latch_a: assert property (
    exec_now && tbl_rd |=> table_read_high_latch_reg == $past(pm_word[15:8])
      && dmem[$past(ea)] == $past(pm_word[7:0]))
    else $error("table read split wrong");
  last_page_a: assert property (
    exec_now && last_page |-> pm_addr[PM_AW-1:8] == '1
      && pm_addr[7:0] == tp_low)
    else $error("last-page address wrong");
  tbl_inc_a: assert property (
    exec_now && inc_op(op_reg) |=> table_pointer_low_reg == $past(table_pointer_low_inc))
    else $error("table pointer not advanced");
  xor_flag_a: assert property (
    exec_now && op_reg == OP_XOR |=> acc_reg == ($past(acc_reg) ^ $past(m))
      && fl_nz == $past(fl_nz) && flags_reg[FLG_Z] == (acc_reg == 8'h00))
    else $error("xor result or flags wrong");
  add_sum_a: assert property (
    exec_now && (op_reg == OP_FADC || op_reg == OP_FADD)
      |=> {flags_reg[FLG_C], acc_reg} == $past(sum))
    else $error("far add result wrong");
  clr_byte_a: assert property (
    exec_now && op_reg == OP_FCLR |=> dmem[$past(ea)] == 8'h00
      && flags_reg == $past(flags_reg))
    else $error("far clear wrong");
  daa_flag_a: assert property (
    exec_now && op_reg == OP_FDAA |=> fl_nc == $past(fl_nc))
    else $error("decimal adjust touched other flags");

  skip_taken_c: cover property (exec_now && skip_now ##2 state_reg == ST_IDLE);
  tbl_read_c:   cover property (exec_now && tbl_rd && inc_op(op_reg));
  add_carry_c:  cover property (exec_now && op_reg == OP_FADC && sum[8]);
  bus_read_c:   cover property (bus_serve && !dp_write_reg);
endmodule
`default_nettype wire

// [hw/instr_exec_pkg.sv]
`default_nettype none
package instr_exec_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] INSTR_OFS = 8'h00;
  localparam logic [7:0] DADDR_OFS = 8'h04;
  localparam logic [7:0] ACC_OFS   = 8'h08;
  localparam logic [7:0] STAT_OFS  = 8'h0C;
  localparam logic [7:0] TBL_OFS   = 8'h10;
  localparam logic [7:0] BANK_OFS  = 8'h14;
  localparam logic [7:0] DMEM_OFS  = 8'h18;
  localparam logic [7:0] PADDR_OFS = 8'h1C;
  localparam logic [7:0] PDATA_OFS = 8'h20;
  // never matches a mapped word; stands in for addresses above the map
  localparam logic [7:0] NOMAP_OFS = 8'hFF;

  // instruction register fields
  localparam int OP_W     = 5;
  localparam int OP_LSB   = 0;
  localparam int BIT_LSB  = 8;
  localparam int IMM_LSB  = 16;
  // table register fields
  localparam int TABLE_POINTER_HIGH_LSB = 8;
  localparam int TABLE_READ_HIGH_LATCH_LSB = 16;
  // status register fields
  localparam int FLG_N    = 5;
  localparam int FLG_C    = 0;
  localparam int FLG_AC   = 1;
  localparam int FLG_Z    = 2;
  localparam int FLG_OV   = 3;
  localparam int FLG_SC   = 4;
  localparam int STAT_SKIP = 8;
  localparam int STAT_BAD  = 9;
  localparam logic [4:0] Z_MASK = 5'h04;
  localparam logic [4:0] C_MASK = 5'h01;

  // reset values
  localparam logic [7:0]      BYTE_RST  = 8'h00;
  localparam logic [4:0]      FLAGS_RST = 5'h00;
  localparam logic [OP_W-1:0] OP_RST    = 5'h00;

  // data memory section: 128 bytes
  localparam int SECT_W = 7;
  // decimal adjust
  localparam logic [3:0] NIB_MAX = 4'h9;
  localparam logic [3:0] BCD_ADJ = 4'h6;
  localparam logic       RESP_OKAY = 1'b0;

  localparam logic [OP_W-1:0] OP_SWAP     = 5'h00;
  localparam logic [OP_W-1:0] OP_NIBBLE_EXCHANGE_TO_ACC    = 5'h01;
  localparam logic [OP_W-1:0] OP_SZ       = 5'h02;
  localparam logic [OP_W-1:0] OP_SZA      = 5'h03;
  localparam logic [OP_W-1:0] OP_SZ_BIT   = 5'h04;
  localparam logic [OP_W-1:0] OP_TRD      = 5'h05;
  localparam logic [OP_W-1:0] OP_TRDL     = 5'h06;
  localparam logic [OP_W-1:0] OP_ITRD     = 5'h07;
  localparam logic [OP_W-1:0] OP_ITRDL    = 5'h08;
  localparam logic [OP_W-1:0] OP_XOR      = 5'h09;
  localparam logic [OP_W-1:0] OP_XOR_TO_MEMORY     = 5'h0A;
  localparam logic [OP_W-1:0] OP_XORI     = 5'h0B;
  localparam logic [OP_W-1:0] OP_FADC     = 5'h0C;
  localparam logic [OP_W-1:0] OP_FADCM    = 5'h0D;
  localparam logic [OP_W-1:0] OP_FADD     = 5'h0E;
  localparam logic [OP_W-1:0] OP_FADDM    = 5'h0F;
  localparam logic [OP_W-1:0] OP_FAND     = 5'h10;
  localparam logic [OP_W-1:0] OP_FANDM    = 5'h11;
  localparam logic [OP_W-1:0] OP_FCLR     = 5'h12;
  localparam logic [OP_W-1:0] OP_FCLR_BIT = 5'h13;
  localparam logic [OP_W-1:0] OP_FCPL     = 5'h14;
  localparam logic [OP_W-1:0] OP_FCPLA    = 5'h15;
  localparam logic [OP_W-1:0] OP_FDAA     = 5'h16;
  localparam logic [OP_W-1:0] OP_FDEC     = 5'h17;
  localparam logic [OP_W-1:0] OP_FDECA    = 5'h18;
  localparam logic [OP_W-1:0] OP_FINC     = 5'h19;
  localparam logic [OP_W-1:0] OP_FINCA    = 5'h1A;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_DUMMY = 3'b100
  } exec_state_e;
endpackage
`default_nettype wire

// [tb/ahb_host.sv]
`timescale 1ns/1ps
`default_nettype none
// bus master standing in for software, one single transfer at a time
module ahb_host (
  // clock
  input  wire logic        ref_clk,
  // bus from the slave
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // bus to the slave
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'b1;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
    // a released data bus must not keep looking valid
    hwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// [tb/mcu_instr_exec_subset_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module mcu_instr_exec_subset_tb
  import instr_exec_pkg::*;
;
  logic        ref_clk;
  logic        reset_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  int          bad_count;
  int          compares;
  int          cycles;

  instr_exec u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp)
  );

  ahb_host u_host (
    .ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata)
  );

  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, {24'h0, a}, d, q);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_host.xfer(1'b0, {24'h0, a}, 32'h0, q);
    chk(q, e);
    chk({31'h0, hresp}, {31'h0, RESP_OKAY});
  endtask

  // i packs address, memory, acc, flags; o packs memory, acc, status
  task automatic go(input logic [4:0] op, input logic [10:0] bi,
                    input logic [31:0] i, input logic [31:0] o);
    wr(DADDR_OFS, {24'h0, i[31:24]});
    wr(DMEM_OFS, {24'h0, i[23:16]});
    wr(ACC_OFS, {24'h0, i[15:8]});
    wr(STAT_OFS, {24'h0, i[7:0]});
    wr(INSTR_OFS, {8'h0, bi[10:3], 5'h0, bi[2:0], 3'h0, op});
    rc(DMEM_OFS, {24'h0, o[31:24]});
    rc(ACC_OFS, {24'h0, o[23:16]});
    rc(STAT_OFS, {16'h0, o[15:0]});
  endtask

  // program word contents depend on every address bit
  function automatic logic [15:0] pw(input logic [8:0] a);
    return {a[8:1] ^ 8'h3C, a[7:0]};
  endfunction

  // returns {sc, ov, z, ac, c, sum}
  function automatic logic [12:0] af(input logic [7:0] a, b,
                                     input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] l;
    logic       ov;
    s  = {1'b0, a} + {1'b0, b} + {8'h0, ci};
    h  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    l  = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h0, ci};
    ov = l[7] ^ s[8];
    return {ov ^ s[7], ov, s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction

  task automatic tr(input logic [4:0] op, input logic [15:0] tp,
                    input logic [8:0] ea);
    logic [15:0] w;
    w = pw(ea);
    wr(TBL_OFS, {16'h0, tp});
    wr(DADDR_OFS, 32'h40);
    wr(STAT_OFS, 32'h1F);
    wr(INSTR_OFS, {27'h0, op});
    rc(DMEM_OFS, {24'h0, w[7:0]});
    rc(TBL_OFS, {8'h0, w[15:8], tp[15:8], ea[7:0]});
    rc(STAT_OFS, 32'h1F);
  endtask

  task automatic t_misc();
    rc(ACC_OFS, 32'h0);
    rc(STAT_OFS, 32'h0);
    rc(TBL_OFS, 32'h0);
    wr(NOMAP_OFS, 32'hFFFF_FFFF);
    rc(NOMAP_OFS, 32'h0);
    go(5'h1B, 11'h0, 32'h5066771F, 32'h6677021F);
  endtask

  task automatic t_swap();
    go(OP_SWAP, 11'h0, 32'h123C5A1F, 32'hC35A001F);
    go(OP_NIBBLE_EXCHANGE_TO_ACC, 11'h0, 32'h123C5A00, 32'h3CC30000);
  endtask

  task automatic t_skip();
    go(OP_SZ, 11'h0, 32'h20007700, 32'h00770100);
    go(OP_SZ, 11'h0, 32'h2001771F, 32'h0177001F);
    go(OP_SZA, 11'h0, 32'h2100771F, 32'h0000011F);
    go(OP_SZA, 11'h0, 32'h21800000, 32'h80800000);
    go(OP_SZ_BIT, 11'h003, 32'h22F7001F, 32'hF700011F);
    go(OP_SZ_BIT, 11'h000, 32'h22010000, 32'h01000000);
  endtask

  task automatic t_xor();
    go(OP_XOR, 11'h0, 32'h305A5A1B, 32'h5A00001F);
    go(OP_XOR_TO_MEMORY, 11'h0, 32'h300FF01F, 32'hFFF0001B);
    go(OP_XORI, 11'h7F8, 32'h30120F00, 32'h12F00000);
  endtask

  task automatic t_table();
    logic [8:0] pa [6] = '{9'h123, 9'h045, 9'h145, 9'h080, 9'h180, 9'h100};
    foreach (pa[k]) begin
      wr(PADDR_OFS, {23'h0, pa[k]});
      wr(PDATA_OFS, {16'h0, pw(pa[k])});
    end
    tr(OP_TRD, 16'h0123, 9'h123);
    tr(OP_TRD, 16'h0045, 9'h045);
    tr(OP_TRDL, 16'h0045, 9'h145);
    tr(OP_ITRD, 16'h007F, 9'h080);
    tr(OP_ITRD, 16'h01FF, 9'h100);
    tr(OP_ITRDL, 16'h007F, 9'h180);
  endtask

  task automatic t_far();
    wr(BANK_OFS, 32'h0);
    wr(DADDR_OFS, 32'h05);
    wr(DMEM_OFS, 32'h33);
    go(OP_FINC, 11'h0, 32'h85100000, 32'h11000000);
    wr(DADDR_OFS, 32'h05);
    rc(DMEM_OFS, 32'h33);
    // with the other section selected a far form must still hit 0x05
    wr(BANK_OFS, 32'h1);
    go(OP_FINC, 11'h0, 32'h05330000, 32'h34000000);
    go(OP_FAND, 11'h0, 32'h90F03C1B, 32'hF030001B);
    go(OP_FANDM, 11'h0, 32'h90F00F1B, 32'h000F001F);
    go(OP_FCLR, 11'h0, 32'h91A5111F, 32'h0011001F);
    go(OP_FCLR_BIT, 11'h003, 32'h91FF111F, 32'hF711001F);
    go(OP_FCPL, 11'h0, 32'h92FF1100, 32'h00110004);
    go(OP_FCPLA, 11'h0, 32'h920F1104, 32'h0FF00000);
    go(OP_FDEC, 11'h0, 32'h9301001B, 32'h0000001F);
    go(OP_FDECA, 11'h0, 32'h93005504, 32'h00FF0000);
    go(OP_FINCA, 11'h0, 32'h93FF551B, 32'hFF00001F);
    go(OP_FDAA, 11'h0, 32'h94001200, 32'h12120000);
    go(OP_FDAA, 11'h0, 32'h94009A00, 32'hA09A0000);
    go(OP_FDAA, 11'h0, 32'h94001501, 32'h75150001);
    go(OP_FDAA, 11'h0, 32'h9400A506, 32'h0BA50007);
  endtask

  // a mid-run reset must bring registers back to their idle values
  task automatic t_reset();
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rc(ACC_OFS, 32'h0);
    rc(STAT_OFS, 32'h0);
    rc(TBL_OFS, 32'h0);
    rc(DADDR_OFS, 32'h0);
  endtask

  // carry preset to 1 so a missing or spurious carry-in shows
  task automatic t_add();
    logic [4:0]  ops [4] = '{OP_FADC, OP_FADCM, OP_FADD, OP_FADDM};
    logic [15:0] prs [4] = '{16'h7F00, 16'h8080, 16'h0F01, 16'hFF01};
    logic [12:0] r;
    logic [7:0]  a;
    logic [7:0]  m;
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) begin
        a = prs[j][15:8];
        m = prs[j][7:0];
        r = af(a, m, i < 2);
        go(ops[i], 11'h0, {8'hA0, m, a, 8'h05},
           {i[0] ? r[7:0] : m, i[0] ? a : r[7:0], 11'h0, r[12:8]});
      end
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // limit is far above the few thousand cycles the scenarios need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    bad_count = 0;
    compares  = 0;
    cycles    = 0;
    reset_n   = 1'b0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_misc();
    t_swap();
    t_skip();
    t_xor();
    t_table();
    t_reset();
    t_far();
    t_add();
    final_report();
  end
endmodule
`default_nettype wire
